// file: pkg/dce_pkg.sv
// Constants for the debug command executor
package dce_pkg;
  // Command codes
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_BACKGROUND = 8'h04;
  localparam logic [7:0] CMD_GO         = 8'h08;
  localparam logic [7:0] CMD_GO_UNTIL   = 8'h0C;
  localparam logic [7:0] CMD_ACK_DIS    = 8'hD5;
  localparam logic [7:0] CMD_ACK_EN     = 8'hD4;
  // Families: base + 4*sz, bit 0 with-status
  localparam logic [7:0] CMD_WRITE_MEM  = 8'h10;
  localparam logic [7:0] CMD_FILL_MEM   = 8'h12;
  localparam logic [7:0] CMD_READ_MEM   = 8'h30;
  localparam logic [7:0] CMD_DUMP_MEM   = 8'h32;
  localparam logic [7:0] CMD_FILL_L_WS  = 8'h1B;
  localparam logic [7:0] FAMILY_MASK    = 8'hF2;
  localparam logic [7:0] CMD_READ_REG   = 8'h60;
  localparam logic [7:0] READ_REG_MASK  = 8'hF0;
  localparam int         SZ_LSB         = 2;
  localparam int         WS_BIT         = 0;
  // Widths
  localparam int         ADDR_W         = 24;
  localparam int         CRN_W          = 4;
  // APB map
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_POINTER   = 12'h008;
  // CTRL fields
  localparam int         CTRL_DAE       = 0;
  localparam logic       CTRL_RESET     = 1'b0;
  // STATUS fields; low byte goes to host
  localparam int         ST_ACTIVE      = 0;
  localparam int         ST_ACK_EN      = 1;
  localparam int         ST_ILLEGAL     = 2;
  localparam int         ST_NO_RESPONSE_FLAG      = 3;
  localparam int         ST_WAIT        = 4;
  localparam int         ST_HALT_PEND   = 5;
  localparam int         ST_DAE         = 6;
  localparam int         ST_BUSY        = 7;
  // Reset values
  localparam logic [ADDR_W-1:0] PTR_RESET = 24'h000000;
  // Previous command class
  typedef enum logic [1:0] {LAST_NEUTRAL, LAST_RD, LAST_WR, LAST_OTHER} dce_last_t;
endpackage

// file: hw/dce_debug_command_executor.sv
// Command executor of the single-wire debug controller
// What this block does
// - Handshake-off clears acknowledge enable and sends no acknowledge itself
// - Handshake-on runs locally, pulses acknowledge once, enables later acknowledges
// - Halt request raises CPU halt only when debug access enable is set
// - Halt during wait stays pending; flags show no-response, wait, not active
// - Sequential read uses pointer then advances it by 1, 2 or 4
// - Read with status sends status after read first; acknowledge precedes data
// - Sequential read legal only after SYNC, no-op, addressed or sequential read
// - Sequential write stores operand at pointer then advances by size
// - Write acknowledge only after the access completes or aborts
// - Write with status returns status after write; long form is 0x1B
// - Sequential write legal only after SYNC, no-op, addressed or sequential write
// - Resume leaves halt, restarts CPU from PC, acknowledges when enabled
// - Resume outside halt mode is illegal and sets the flag
// - Resume-until-halt acknowledges on halt re-entry; no timeout while pending
// - Resume-until-halt outside halt mode is illegal and sets the flag
// - Without handshake, resume-until-halt acts as plain resume
// - Register read returns 32 bits, zero filled; acknowledge precedes data
// - Register read outside halt mode sets flag and makes no access
// - Codes 0x08 resume, 0x0C resume-until-halt, 0x00 no-op
// - Register read code is 0x60 plus register number, then 32-bit data
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module dce_debug_command_executor (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Commands from the serial framer
  input  wire logic        CMD_VALID,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic [23:0] CMD_ADDR,
  input  wire logic [31:0] CMD_WDATA,
  input  wire logic        CMD_SYNC,
  // Answers to the serial framer
  output logic             ACK_PULSE,
  output logic             ILLEGAL_PULSE,
  output logic             RSP_VALID,
  output logic      [31:0] RSP_DATA,
  output logic             RSP_STATUS_VALID,
  output logic      [7:0]  RSP_STATUS,
  output logic             ACK_WAITING,
  output logic             CMD_BUSY,
  // Memory access
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic      [23:0] MEM_ADDR,
  output logic      [1:0]  MEM_SIZE,
  output logic      [31:0] MEM_WDATA,
  input  wire logic        MEM_DONE,
  input  wire logic        MEM_ABORT,
  input  wire logic [31:0] MEM_RDATA,
  // CPU control
  output logic             CPU_HALT_REQ,
  output logic             CPU_RESUME,
  output logic             CPU_REG_REQ,
  output logic      [3:0]  CPU_REG_NUM,
  input  wire logic        CPU_HALTED,
  input  wire logic        CPU_WAIT,
  input  wire logic        CPU_REG_DONE,
  input  wire logic [31:0] CPU_REG_DATA
);

  typedef enum logic [2:0] {S_IDLE, S_MEM, S_REG, S_DATA, S_GO_RUN, S_GO_HALT} dce_state_t;

  // Operand size in bytes
  function automatic logic [23:0] size_bytes(input logic [1:0] sz);
    size_bytes = (sz == 2'd0) ? 24'h000001 : (sz == 2'd1) ? 24'h000002 : 24'h000004;
  endfunction

  // Clear low address bits for size
  function automatic logic [23:0] align(input logic [23:0] a, input logic [1:0] sz);
    align = (sz == 2'd0) ? a : (sz == 2'd1) ? {a[23:1], 1'b0} : {a[23:2], 2'b00};
  endfunction

  dce_state_t        state_ff, nxt_state;
  dce_pkg::dce_last_t last_ff, nxt_last;
  logic [23:0]       ptr_ff, nxt_ptr;
  logic              ack_en_ff, nxt_ack_en;
  logic              dae_ff;
  logic              ill_ff;
  logic              halt_req_ff, nxt_halt_req;
  logic              is_write_ff, nxt_is_write;
  logic              is_ws_ff, nxt_is_ws;
  logic [1:0]        sz_ff, nxt_sz;
  logic [31:0]       data_ff, nxt_data;
  logic              ack_ff, nxt_ack;
  logic              ill_pulse_ff, nxt_ill_pulse;
  logic              rsp_ff, nxt_rsp;
  logic              st_valid_ff, nxt_st_valid;
  logic              mem_req_ff, nxt_mem_req;
  logic              resume_ff, nxt_resume;
  logic              reg_req_ff, nxt_reg_req;
  logic [3:0]        crn_ff, nxt_crn;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;

  // Command decode
  wire [1:0] cmd_sz     = CMD_CODE[dce_pkg::SZ_LSB +: 2];
  wire       cmd_ws     = CMD_CODE[dce_pkg::WS_BIT];
  wire [7:0] cmd_family = CMD_CODE & dce_pkg::FAMILY_MASK;
  wire       sz_ok      = (cmd_sz != 2'd3);
  wire       is_rd_mem  = sz_ok && (cmd_family == dce_pkg::CMD_READ_MEM);
  wire       is_wr_mem  = sz_ok && (cmd_family == dce_pkg::CMD_WRITE_MEM);
  wire       is_dump    = sz_ok && (cmd_family == dce_pkg::CMD_DUMP_MEM);
  wire       is_fill    = sz_ok && (cmd_family == dce_pkg::CMD_FILL_MEM);
  wire       is_rd_reg  = (CMD_CODE & dce_pkg::READ_REG_MASK) == dce_pkg::CMD_READ_REG;
  wire       is_go      = CMD_CODE == dce_pkg::CMD_GO;
  wire       is_go_unt  = CMD_CODE == dce_pkg::CMD_GO_UNTIL;
  wire       is_nop     = CMD_CODE == dce_pkg::CMD_NOP;
  wire       dump_legal = (last_ff == dce_pkg::LAST_NEUTRAL) || (last_ff == dce_pkg::LAST_RD);
  wire       fill_legal = (last_ff == dce_pkg::LAST_NEUTRAL) || (last_ff == dce_pkg::LAST_WR);
  wire       take_cmd   = CMD_VALID && (state_ff == S_IDLE) && !CMD_SYNC;
  wire       mem_end    = MEM_DONE || MEM_ABORT;

  // Status byte, reflects the live state
  wire       no_resp    = halt_req_ff && !CPU_HALTED && CPU_WAIT;
  wire [7:0] status_byte;
  assign status_byte[dce_pkg::ST_ACTIVE]    = CPU_HALTED;
  assign status_byte[dce_pkg::ST_ACK_EN]    = ack_en_ff;
  assign status_byte[dce_pkg::ST_ILLEGAL]   = ill_ff;
  assign status_byte[dce_pkg::ST_NO_RESPONSE_FLAG]    = no_resp;
  assign status_byte[dce_pkg::ST_WAIT]      = CPU_WAIT;
  assign status_byte[dce_pkg::ST_HALT_PEND] = halt_req_ff && !CPU_HALTED;
  assign status_byte[dce_pkg::ST_DAE]       = dae_ff;
  assign status_byte[dce_pkg::ST_BUSY]      = state_ff != S_IDLE;

  // Status with this access's abort
  wire [7:0] status_now = status_byte | ({7'h00, MEM_ABORT} << dce_pkg::ST_ILLEGAL);

  // APB decode
  wire       apb_setup  = PSEL && !PENABLE;
  wire       apb_wr     = PSEL && PENABLE && PWRITE && pready_ff;
  wire       hit_ctrl   = PADDR == dce_pkg::OFS_CTRL;
  wire       hit_status = PADDR == dce_pkg::OFS_STATUS;
  wire       hit_ptr    = PADDR == dce_pkg::OFS_POINTER;
  wire       apb_hit    = hit_ctrl || hit_status || hit_ptr;
  wire [31:0] apb_rdata = hit_ctrl   ? {31'h0, dae_ff} :
                          hit_status ? {24'h0, status_byte} :
                          hit_ptr    ? {8'h0, ptr_ff} : 32'h0;
  wire       ill_clear  = apb_wr && hit_status && PWDATA[dce_pkg::ST_ILLEGAL];
  wire       ill_set    = nxt_ill_pulse || (state_ff == S_MEM && MEM_ABORT);

  // Command sequencing
  always_comb begin
    nxt_state     = state_ff;
    nxt_last      = last_ff;
    nxt_ptr       = ptr_ff;
    nxt_ack_en    = ack_en_ff;
    nxt_halt_req  = halt_req_ff;
    nxt_is_write  = is_write_ff;
    nxt_is_ws     = is_ws_ff;
    nxt_sz        = sz_ff;
    nxt_data      = data_ff;
    nxt_crn       = crn_ff;
    nxt_ack       = 1'b0;
    nxt_ill_pulse = 1'b0;
    nxt_rsp       = 1'b0;
    nxt_st_valid  = 1'b0;
    nxt_resume    = 1'b0;
    nxt_mem_req   = mem_req_ff;
    nxt_reg_req   = reg_req_ff;
    if (CPU_HALTED) begin
      nxt_halt_req = 1'b0;
    end
    if (CMD_SYNC) begin
      // Abort all, incl. pending ack
      nxt_state   = S_IDLE;
      nxt_last    = dce_pkg::LAST_NEUTRAL;
      nxt_mem_req = 1'b0;
      nxt_reg_req = 1'b0;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (take_cmd) begin
            nxt_last = dce_pkg::LAST_OTHER;
            if (CMD_CODE == dce_pkg::CMD_ACK_DIS) begin
              nxt_ack_en = 1'b0;
            end else if (CMD_CODE == dce_pkg::CMD_ACK_EN) begin
              nxt_ack_en = 1'b1;
              nxt_ack    = 1'b1;
            end else if (is_nop) begin
              nxt_last = dce_pkg::LAST_NEUTRAL;
              nxt_ack  = ack_en_ff;
            end else if (CMD_CODE == dce_pkg::CMD_BACKGROUND) begin
              nxt_halt_req = dae_ff && !CPU_HALTED;
              nxt_ack      = ack_en_ff;
            end else if (is_go || is_go_unt) begin
              if (!CPU_HALTED) begin
                nxt_ill_pulse = 1'b1;
              end else begin
                nxt_resume = 1'b1;
                if (is_go_unt && ack_en_ff) begin
                  nxt_state = S_GO_RUN;
                end else begin
                  nxt_ack = ack_en_ff;
                end
              end
            end else if (is_rd_mem || is_wr_mem) begin
              nxt_ptr  = align(CMD_ADDR, cmd_sz) + size_bytes(cmd_sz);
              nxt_last = is_rd_mem ? dce_pkg::LAST_RD : dce_pkg::LAST_WR;
            end else if (is_dump || is_fill) begin
              if ((is_dump && dump_legal) || (is_fill && fill_legal)) begin
                nxt_is_write = is_fill;
                nxt_is_ws    = cmd_ws;
                nxt_sz       = cmd_sz;
                nxt_data     = CMD_WDATA;
                nxt_mem_req  = 1'b1;
                nxt_last     = is_dump ? dce_pkg::LAST_RD : dce_pkg::LAST_WR;
                nxt_state    = S_MEM;
              end else begin
                nxt_ill_pulse = 1'b1;
              end
            end else if (is_rd_reg) begin
              if (!CPU_HALTED) begin
                nxt_ill_pulse = 1'b1;
              end else begin
                nxt_crn     = CMD_CODE[dce_pkg::CRN_W-1:0];
                nxt_reg_req = 1'b1;
                nxt_state   = S_REG;
              end
            end
          end
        end
        S_MEM: begin
          if (mem_end) begin
            nxt_mem_req = 1'b0;
            nxt_ptr     = ptr_ff + size_bytes(sz_ff);
            if (is_write_ff) begin
              nxt_ack      = ack_en_ff && !is_ws_ff;
              nxt_st_valid = is_ws_ff;
              nxt_state    = S_IDLE;
            end else begin
              nxt_data     = MEM_ABORT ? 32'h0 : MEM_RDATA;
              nxt_st_valid = is_ws_ff;
              nxt_ack      = ack_en_ff && !is_ws_ff;
              nxt_state    = S_DATA;
            end
          end
        end
        S_REG: begin
          if (CPU_REG_DONE) begin
            nxt_reg_req = 1'b0;
            nxt_data    = CPU_REG_DATA;
            nxt_ack     = ack_en_ff;
            nxt_state   = S_DATA;
          end
        end
        S_DATA: begin
          nxt_rsp   = 1'b1;
          nxt_state = S_IDLE;
        end
        S_GO_RUN: begin
          if (!CPU_HALTED) begin
            nxt_state = S_GO_HALT;
          end
        end
        S_GO_HALT: begin
          if (CPU_HALTED) begin
            nxt_ack   = 1'b1;
            nxt_state = S_IDLE;
          end
        end
        default: begin
          nxt_state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff     <= S_IDLE;
      last_ff      <= dce_pkg::LAST_NEUTRAL;
      ptr_ff       <= dce_pkg::PTR_RESET;
      ack_en_ff    <= 1'b0;
      halt_req_ff  <= 1'b0;
      is_write_ff  <= 1'b0;
      is_ws_ff     <= 1'b0;
      sz_ff        <= 2'd0;
      data_ff      <= 32'h0;
      crn_ff       <= 4'h0;
      ack_ff       <= 1'b0;
      ill_pulse_ff <= 1'b0;
      rsp_ff       <= 1'b0;
      st_valid_ff  <= 1'b0;
      mem_req_ff   <= 1'b0;
      resume_ff    <= 1'b0;
      reg_req_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      last_ff      <= nxt_last;
      ptr_ff       <= nxt_ptr;
      ack_en_ff    <= nxt_ack_en;
      halt_req_ff  <= nxt_halt_req;
      is_write_ff  <= nxt_is_write;
      is_ws_ff     <= nxt_is_ws;
      sz_ff        <= nxt_sz;
      data_ff      <= nxt_data;
      crn_ff       <= nxt_crn;
      ack_ff       <= nxt_ack;
      ill_pulse_ff <= nxt_ill_pulse;
      rsp_ff       <= nxt_rsp;
      st_valid_ff  <= nxt_st_valid;
      mem_req_ff   <= nxt_mem_req;
      resume_ff    <= nxt_resume;
      reg_req_ff   <= nxt_reg_req;
    end
  end

  // Status byte held with result
  logic [7:0] status_ff;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_ff <= 8'h00;
    end else if (nxt_st_valid) begin
      status_ff <= status_now;
    end
  end

  // Sticky illegal flag, set wins
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ill_ff <= 1'b0;
    end else if (ill_set) begin
      ill_ff <= 1'b1;
    end else if (ill_clear) begin
      ill_ff <= 1'b0;
    end
  end

  // APB slave, no wait state on any access; PREADY is registered from the setup phase
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dae_ff     <= dce_pkg::CTRL_RESET;
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup && !apb_hit;
      prdata_ff  <= (apb_setup && !PWRITE) ? apb_rdata : 32'h0;
      if (apb_wr && hit_ctrl) begin
        dae_ff <= PWDATA[dce_pkg::CTRL_DAE];
      end
    end
  end

  assign PRDATA           = prdata_ff;
  assign PREADY           = pready_ff;
  assign PSLVERR          = pslverr_ff;
  assign ACK_PULSE        = ack_ff;
  assign ILLEGAL_PULSE    = ill_pulse_ff;
  assign RSP_VALID        = rsp_ff;
  assign RSP_DATA         = data_ff;
  assign RSP_STATUS_VALID = st_valid_ff;
  assign RSP_STATUS       = status_ff;
  assign ACK_WAITING      = (state_ff == S_GO_RUN) || (state_ff == S_GO_HALT);
  assign CMD_BUSY         = state_ff != S_IDLE;
  assign MEM_REQ          = mem_req_ff;
  assign MEM_WE           = is_write_ff;
  assign MEM_ADDR         = ptr_ff;
  assign MEM_SIZE         = sz_ff;
  assign MEM_WDATA        = data_ff;
  assign CPU_HALT_REQ     = halt_req_ff;
  assign CPU_RESUME       = resume_ff;
  assign CPU_REG_REQ      = reg_req_ff;
  assign CPU_REG_NUM      = crn_ff;

endmodule

// file: sim/dce_properties.sv
// Port checks for the debug command executor
`timescale 1ns/1ps
module dce_checker (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RESETN,
  // Commands and answers
  input wire logic       CMD_VALID,
  input wire logic [7:0] CMD_CODE,
  input wire logic       CMD_SYNC,
  input wire logic       CMD_BUSY,
  input wire logic       ACK_PULSE,
  input wire logic       ILLEGAL_PULSE,
  // Memory and CPU
  input wire logic       MEM_REQ,
  input wire logic       MEM_WE,
  input wire logic [1:0] MEM_SIZE,
  input wire logic       CPU_HALT_REQ,
  input wire logic       CPU_RESUME,
  input wire logic       CPU_REG_REQ,
  input wire logic [3:0] CPU_REG_NUM,
  input wire logic       CPU_HALTED
);
  logic       take;
  logic       bg_ff;
  logic [7:0] code_ff;
  assign take = CMD_VALID && !CMD_BUSY && !CMD_SYNC;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bg_ff   <= 1'b0;
      code_ff <= 8'h00;
    end else begin
      bg_ff   <= take && CMD_CODE == dce_pkg::CMD_BACKGROUND;
      code_ff <= take ? CMD_CODE : code_ff;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence take_s(logic [7:0] c);
    take && CMD_CODE == c;
  endsequence
  ack_off_quiet_a: assert property (take_s(dce_pkg::CMD_ACK_DIS) |=> !ACK_PULSE)
    else $error("ack after ack off");
  ack_on_pulse_a: assert property (take_s(dce_pkg::CMD_ACK_EN) |=> ACK_PULSE)
    else $error("no ack on enable");
  halt_cause_a: assert property ($rose(CPU_HALT_REQ) |-> bg_ff)
    else $error("stray halt request");
  access_size_a: assert property ($rose(MEM_REQ) |-> MEM_SIZE == code_ff[3:2])
    else $error("wrong access size");
  write_ack_late_a: assert property (MEM_REQ && MEM_WE |-> !ACK_PULSE)
    else $error("early write ack");
  go_refused_a: assert property (take_s(dce_pkg::CMD_GO) ##0 !CPU_HALTED |=>
    ILLEGAL_PULSE && !CPU_RESUME) else $error("go not refused");
  until_refused_a: assert property (take_s(dce_pkg::CMD_GO_UNTIL) ##0 !CPU_HALTED
    |=> ILLEGAL_PULSE) else $error("go-until not refused");
  reg_refused_a: assert property (take && CMD_CODE[7:4] == 4'h6 && !CPU_HALTED |=>
    ILLEGAL_PULSE && !CPU_REG_REQ ##1 !CPU_REG_REQ [*3]) else $error("register read not refused");
  reg_number_a: assert property ($rose(CPU_REG_REQ) |-> CPU_REG_NUM == code_ff[3:0])
    else $error("wrong register");
  go_resume_a: assert property (take_s(dce_pkg::CMD_GO) ##0 CPU_HALTED |-> ##[1:4] CPU_RESUME)
    else $error("no resume");
endmodule
bind dce_debug_command_executor dce_checker u_dce_checker (.*);

// file: sim/dce_mem_cpu_model.sv
// Memory and CPU model on the internal side of the executor
`timescale 1ns/1ps
module dce_mem_cpu_model (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // Memory
  input wire logic         mem_req,
  input wire logic         mem_we,
  input wire logic [23:0]  mem_addr,
  input wire logic [1:0]   mem_size,
  input wire logic [31:0]  mem_wdata,
  output logic             mem_done,
  output logic [31:0]      mem_rdata,
  output logic [23:0]      wr_addr,
  output logic [31:0]      wr_data,
  // CPU
  input wire logic         halt_req,
  input wire logic         resume,
  input wire logic         reg_req,
  input wire logic [3:0]   reg_num,
  input wire logic         bp_en,
  output logic             halted,
  output logic             reg_done,
  output logic [31:0]      reg_data
);
  int       slow;
  logic [7:0] cnt;
  initial begin
    mem_done  = 1'b0;
    mem_rdata = 32'h00000000;
    slow      = 1;
  end
  // Answers alternately soon and after a stall; bus inverted when idle
  always begin
    @(posedge clk);
    if (rst_n && mem_req) begin
      repeat (slow) @(posedge clk);
      slow = 5 - slow;
      if (mem_we) begin
        wr_addr <= mem_addr;
        wr_data <= mem_wdata;
      end
      mem_rdata <= {8'h5A, mem_addr} & (mem_size == 2'd0 ? 32'hFF :
                   mem_size == 2'd1 ? 32'hFFFF : 32'hFFFFFFFF);
      mem_done  <= 1'b1;
      @(posedge clk);
      mem_done  <= 1'b0;
      mem_rdata <= ~mem_rdata;
      while (mem_req) @(posedge clk);
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halted   <= 1'b0;
      cnt      <= 8'h00;
      reg_done <= 1'b0;
      reg_data <= 32'h00000000;
    end else begin
      reg_done <= reg_req && !reg_done;
      reg_data <= reg_req ? {24'h000000, 4'hC, reg_num} : ~reg_data;
      if (resume) begin
        halted <= 1'b0;
        cnt    <= bp_en ? 8'd20 : 8'd0;
      end else if (halt_req && !halted && cnt == 8'd0) begin
        cnt <= 8'd3;
      end else if (cnt == 8'd1) begin
        halted <= 1'b1;
        cnt    <= 8'd0;
      end else if (cnt != 8'd0) begin
        cnt <= cnt - 8'd1;
      end
    end
  end
endmodule

// file: sim/tb.sv
// Self-checking bench for the debug command executor
`timescale 1ns/1ps
module tb;
  logic        CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CMD_VALID, CMD_SYNC;
  logic        ACK_PULSE, ILLEGAL_PULSE, RSP_VALID, RSP_STATUS_VALID, ACK_WAITING, CMD_BUSY;
  logic        MEM_REQ, MEM_WE, MEM_DONE, CPU_HALT_REQ, CPU_RESUME, CPU_REG_REQ, CPU_HALTED;
  logic        CPU_REG_DONE, err, loose, bp_en;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, CMD_WDATA, RSP_DATA, MEM_WDATA, MEM_RDATA, CPU_REG_DATA;
  logic [31:0] wr_data, rd, d, m;
  logic [7:0]  CMD_CODE, RSP_STATUS;
  logic [23:0] CMD_ADDR, MEM_ADDR, wr_addr, a;
  logic [1:0]  MEM_SIZE;
  logic [3:0]  CPU_REG_NUM;
  logic [1:0]  exp_k[$];
  logic [31:0] exp_v[$];
  logic [7:0]  fc[3] = '{8'h1A, dce_pkg::CMD_FILL_L_WS, 8'h16};
  logic [7:0]  bad[3] = '{dce_pkg::CMD_GO, dce_pkg::CMD_GO_UNTIL, 8'h63};
  int          n_fail, checked, seed;
  dce_debug_command_executor u_dce_debug_command_executor (.CLK, .RESETN, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CMD_VALID, .CMD_CODE, .CMD_ADDR,
    .CMD_WDATA, .CMD_SYNC, .ACK_PULSE, .ILLEGAL_PULSE, .RSP_VALID, .RSP_DATA, .RSP_STATUS_VALID,
    .RSP_STATUS, .ACK_WAITING, .CMD_BUSY, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_SIZE, .MEM_WDATA,
    .MEM_DONE, .MEM_ABORT(1'b0), .MEM_RDATA, .CPU_HALT_REQ, .CPU_RESUME, .CPU_REG_REQ,
    .CPU_REG_NUM, .CPU_HALTED, .CPU_WAIT(1'b0), .CPU_REG_DONE, .CPU_REG_DATA);
  dce_mem_cpu_model u_dce_mem_cpu_model (.clk(CLK), .rst_n(RESETN), .mem_req(MEM_REQ),
    .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_size(MEM_SIZE), .mem_wdata(MEM_WDATA),
    .mem_done(MEM_DONE), .mem_rdata(MEM_RDATA), .wr_addr(wr_addr), .wr_data(wr_data),
    .halt_req(CPU_HALT_REQ), .resume(CPU_RESUME), .reg_req(CPU_REG_REQ), .reg_num(CPU_REG_NUM),
    .bp_en(bp_en), .halted(CPU_HALTED), .reg_done(CPU_REG_DONE), .reg_data(CPU_REG_DATA));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  function automatic logic [31:0] mdat(logic [23:0] ad, int s);
    mdat = {8'h5A, ad} & (s == 0 ? 32'hFF : s == 1 ? 32'hFFFF : 32'hFFFFFFFF);
  endfunction
  task cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task expect_res(input logic [1:0] k, input logic [31:0] v = 32'h0);
    exp_k.push_back(k);
    exp_v.push_back(v);
  endtask
  // Kinds: 0 ack, 1 illegal, 2 status, 3 data
  task take_res(input logic [1:0] k, input logic [31:0] v);
    if (exp_k.size() == 0) begin
      n_fail++;
      $display("FAIL %0t stray result %0d", $time, k);
    end else begin
      cmp_word({30'h0, k}, {30'h0, exp_k.pop_front()}, "result kind");
      cmp_word(v, exp_v.pop_front(), "result value");
    end
  endtask
  always @(posedge CLK) begin
    if (RESETN === 1'b1 && !loose) begin
      if (ACK_PULSE === 1'b1) take_res(2'd0, 32'h0);
      if (ILLEGAL_PULSE === 1'b1) take_res(2'd1, 32'h0);
      if (RSP_STATUS_VALID === 1'b1) take_res(2'd2, {24'h0, RSP_STATUS & 8'h07});
      if (RSP_VALID === 1'b1) take_res(2'd3, RSP_DATA);
    end
  end
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd = 32'h0);
    int i;
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= ad;
    PWDATA  <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (PREADY !== 1'b1 && i < 20);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task cmd(input logic [7:0] c, input logic [23:0] ad = 24'h0, input logic [31:0] wd = 32'h0);
    int i;
    @(posedge CLK);
    for (i = 0; i < 400 && CMD_BUSY !== 1'b0; i++) @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD_CODE  <= c;
    CMD_ADDR  <= ad;
    CMD_WDATA <= wd;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    repeat (2) @(posedge CLK);
    for (i = 0; i < 400 && CMD_BUSY !== 1'b0; i++) @(posedge CLK);
    repeat (3) @(posedge CLK);
  endtask
  task end_test(input string s);
    cmp_word(32'(exp_k.size()), 32'h0, "results missing");
    $display("test %s done", s);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #25000;
    n_fail++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    seed = 32'h17b3;
    {PSEL, PENABLE, PWRITE, CMD_VALID, CMD_SYNC, loose, bp_en, RESETN} = 8'h00;
    {PADDR, PWDATA, CMD_CODE, CMD_ADDR, CMD_WDATA} = 108'h0;
    n_fail = 0;
    checked = 0;
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    apb(1'b1, dce_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, dce_pkg::OFS_CTRL);
    cmp_word(rd, 32'h1, "enable readback");
    apb(1'b0, dce_pkg::OFS_POINTER);
    cmp_word(rd, 32'h0, "pointer reset");
    apb(1'b0, 12'hFFC);
    cmp_word({31'h0, err}, 32'h1, "unmapped error");
    end_test("registers");
    expect_res(2'd0);
    cmd(dce_pkg::CMD_ACK_EN);
    cmd(dce_pkg::CMD_ACK_DIS);
    cmd(dce_pkg::CMD_NOP);
    expect_res(2'd0);
    cmd(dce_pkg::CMD_ACK_EN);
    end_test("handshake");
    loose = 1'b1;
    cmd(8'h38, 24'h001000);
    loose = 1'b0;
    a = 24'h001004;
    for (int s = 2; s >= 0; s--) begin
      expect_res(2'd0);
      expect_res(2'd3, mdat(a, s));
      cmd(dce_pkg::CMD_DUMP_MEM | (8'(s) << dce_pkg::SZ_LSB));
      a = a + (24'h1 << s);
    end
    expect_res(2'd0);
    cmd(dce_pkg::CMD_NOP);
    expect_res(2'd2, 32'h2);
    expect_res(2'd3, mdat(a, 0));
    cmd(dce_pkg::CMD_DUMP_MEM | 8'h01);
    apb(1'b0, dce_pkg::OFS_POINTER);
    cmp_word(rd, {8'h0, a + 24'h1}, "ptr after dumps");
    end_test("dump");
    expect_res(2'd1);
    cmd(dce_pkg::CMD_FILL_MEM);
    apb(1'b1, dce_pkg::OFS_STATUS, 32'h4);
    loose = 1'b1;
    cmd(8'h18, 24'h002000);
    loose = 1'b0;
    a = 24'h002004;
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      m = mdat(24'hFFFFFF, i == 2 ? 1 : 2);
      expect_res(i == 1 ? 2'd2 : 2'd0, i == 1 ? 32'h2 : 32'h0);
      cmd(fc[i], 24'h0, d);
      cmp_word({8'h0, wr_addr}, {8'h0, a}, "fill address");
      cmp_word(wr_data & m, d & m, "fill data");
      a = a + (i == 2 ? 24'h2 : 24'h4);
    end
    end_test("fill");
    for (int i = 0; i < 3; i++) begin
      expect_res(2'd1);
      cmd(bad[i]);
    end
    apb(1'b1, dce_pkg::OFS_STATUS, 32'h4);
    end_test("refused");
    expect_res(2'd0);
    cmd(dce_pkg::CMD_BACKGROUND);
    repeat (16) @(posedge CLK);
    apb(1'b0, dce_pkg::OFS_STATUS);
    cmp_word(rd & 32'h1, 32'h1, "halted flag");
    expect_res(2'd0);
    expect_res(2'd3, 32'h000000C5);
    cmd(8'h65);
    cmd(dce_pkg::CMD_GO_UNTIL);
    cmp_word({31'h0, ACK_WAITING}, 32'h1, "ack pending");
    CMD_SYNC <= 1'b1;
    @(posedge CLK);
    CMD_SYNC <= 1'b0;
    @(posedge CLK);
    cmp_word({31'h0, ACK_WAITING}, 32'h0, "sync ends wait");
    expect_res(2'd0);
    cmd(dce_pkg::CMD_BACKGROUND);
    repeat (16) @(posedge CLK);
    bp_en <= 1'b1;
    expect_res(2'd0);
    cmd(dce_pkg::CMD_GO_UNTIL);
    expect_res(2'd0);
    cmd(dce_pkg::CMD_GO);
    for (int i = 0; i < 100 && CPU_HALTED !== 1'b1; i++) @(posedge CLK);
    end_test("halt and resume");
    cmd(dce_pkg::CMD_ACK_DIS);
    bp_en <= 1'b0;
    cmd(dce_pkg::CMD_GO_UNTIL);
    cmp_word({31'h0, CPU_HALTED}, 32'h0, "still running");
    cmp_word({31'h0, ACK_WAITING}, 32'h0, "no ack pending");
    end_test("no handshake");
    wrap_up();
  end
endmodule
